/* verilog/phy_misc_extended_regs.sv */
// Summary of operation
// - 10 Mbps transmit start indication delayed by bits [12:8] times 8 ns.
// - 100 Mbps transmit start indication delayed by bits [7:4] times 8 ns.
// - Depth-unit bit one counts FIFO in bytes, zero in nibbles; resets one.
// - Byte units in nibble MII mode give a larger prefill and latency.
// - Sixteen-bit counter counts wake sequences that miss their time limit.
// - Each host read of the wake fault count clears it.
// - Bit 0 set selects reduced-voltage 10 Mbps transmit; resets to one.
// - Codes 001 and 010 send 10 MHz square wave on pair 0, 1.
// - Codes 011 and 100 send 5 MHz square wave on pair 0, 1.
// - Code 000 disables test waveform; codes 101 to 111 are reserved.
// - Start detection follows the transmit FIFO when it is in use, else the MII, and needs detection enabled.
`timescale 1ns/10ps
`include "phy_misc_cfg.svh"

module phy_misc_extended_regs
  import phy_misc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire mgmt_req_type MGMT_REQ,
  output mgmt_rsp_type MGMT_RSP,
  input wire logic LINK_SPEED_100,
  input wire logic TX_DETECT_EN,
  input wire logic TX_FIFO_IN_USE,
  input wire logic TX_FIFO_FRAME_START,
  input wire logic TX_MII_FRAME_START,
  input wire logic WAKE_FAULT,
  output logic TX_START_IND,
  output logic FIFO_DEPTH_BYTES,
  output logic [3:0] FIFO_PREFILL_NIBBLES,
  output logic REDUCED_SWING_10M,
  output logic TEST_PAIR0_EN,
  output logic TEST_PAIR1_EN,
  output logic TEST_RATE_10M
);

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  logic [4:0] dly10_ff, nxt_dly10;
  logic [3:0] dly100_ff, nxt_dly100;
  logic unit_ff, nxt_unit;
  logic swing_ff, nxt_swing;
  logic [2:0] wave_ff, nxt_wave;

  always_comb
  begin
    nxt_dly10 = dly10_ff;
    nxt_dly100 = dly100_ff;
    nxt_unit = unit_ff;
    nxt_swing = swing_ff;
    nxt_wave = wave_ff;
    if (MGMT_REQ.wr)
    begin
      // Only defined fields are stored, so reserved bits stay zero.
      unique case (MGMT_REQ.addr)
        `OFS_TX_SOP_DELAY:
        begin
          nxt_dly10 = MGMT_REQ.wdata[`DLY10_MSB:`DLY10_LSB];
          nxt_dly100 = MGMT_REQ.wdata[`DLY100_MSB:`DLY100_LSB];
        end
        `OFS_FIFO_DEPTH_UNIT: nxt_unit = MGMT_REQ.wdata[`UNIT_BIT];
        `OFS_REDUCED_SWING: nxt_swing = MGMT_REQ.wdata[`SWING_BIT];
        `OFS_TEST_WAVE_10M: nxt_wave = MGMT_REQ.wdata[`WAVE_MSB:0];
        default: nxt_wave = wave_ff;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      dly10_ff <= `RST_DLY10;
      dly100_ff <= `RST_DLY100;
      unit_ff <= `RST_UNIT_BYTES;
      swing_ff <= `RST_REDUCED_SWING;
      wave_ff <= `RST_WAVE_SEL;
    end
    else
    begin
      dly10_ff <= nxt_dly10;
      dly100_ff <= nxt_dly100;
      unit_ff <= nxt_unit;
      swing_ff <= nxt_swing;
      wave_ff <= nxt_wave;
    end
  end

  // --------------------------------------------------------------------------
  // Wake fault counter
  // --------------------------------------------------------------------------
  logic [15:0] wake_count;
  logic wake_read;

  assign wake_read = MGMT_REQ.rd && (MGMT_REQ.addr == `OFS_WAKE_FAULT_COUNT);

  wake_fault_counter u_wake
  (
    .clk(CLK_SYS),
    .rst(RST),
    .fault(WAKE_FAULT),
    .clear(wake_read),
    .count(wake_count)
  );

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  mgmt_rsp_type rsp_ff, nxt_rsp;

  always_comb
  begin
    nxt_rsp.rvalid = MGMT_REQ.rd;
    nxt_rsp.rdata = 16'h0000;
    if (MGMT_REQ.rd)
    begin
      unique case (MGMT_REQ.addr)
        `OFS_TX_SOP_DELAY: nxt_rsp.rdata = {3'h0, dly10_ff, dly100_ff, 4'h0};
        `OFS_FIFO_DEPTH_UNIT: nxt_rsp.rdata = {15'h0000, unit_ff};
        `OFS_WAKE_FAULT_COUNT: nxt_rsp.rdata = wake_count;
        `OFS_REDUCED_SWING: nxt_rsp.rdata = {15'h0000, swing_ff};
        `OFS_TEST_WAVE_10M: nxt_rsp.rdata = {13'h0000, wave_ff};
        default: nxt_rsp.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      rsp_ff <= '0;
    else
      rsp_ff <= nxt_rsp;
  end

  assign MGMT_RSP = rsp_ff;

  // --------------------------------------------------------------------------
  // Transmit start-of-packet indication
  // --------------------------------------------------------------------------
  logic sop_start;
  logic [7:0] sop_delay_ns;

  // With the FIFO in use the start is taken at the FIFO output.
  assign sop_start = TX_DETECT_EN && (TX_FIFO_IN_USE ? TX_FIFO_FRAME_START : TX_MII_FRAME_START);
  assign sop_delay_ns = LINK_SPEED_100 ? 8'({dly100_ff, 3'h0}) : 8'({dly10_ff, 3'h0});

  sop_tx_delay u_sop
  (
    .clk(CLK_SYS),
    .rst(RST),
    .start(sop_start),
    .delay_ns(sop_delay_ns),
    .pulse(TX_START_IND)
  );

  // --------------------------------------------------------------------------
  // Steering outputs
  // --------------------------------------------------------------------------
  logic depth_ff, nxt_depth;
  logic [3:0] prefill_ff, nxt_prefill;
  logic swing_out_ff, nxt_swing_out;
  logic pair0_ff, nxt_pair0;
  logic pair1_ff, nxt_pair1;
  logic rate_ff, nxt_rate;

  always_comb
  begin
    nxt_depth = unit_ff;
    nxt_prefill = unit_ff ? 4'(`PREFILL_UNITS << 1) : `PREFILL_UNITS;
    nxt_swing_out = swing_ff;
    nxt_pair0 = 1'b0;
    nxt_pair1 = 1'b0;
    nxt_rate = 1'b0;
    unique case (wave_ff)
      `WAVE_10M_PAIR0:
      begin
        nxt_pair0 = 1'b1;
        nxt_rate = 1'b1;
      end
      `WAVE_10M_PAIR1:
      begin
        nxt_pair1 = 1'b1;
        nxt_rate = 1'b1;
      end
      `WAVE_5M_PAIR0: nxt_pair0 = 1'b1;
      `WAVE_5M_PAIR1: nxt_pair1 = 1'b1;
      default: nxt_pair0 = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      depth_ff <= `RST_UNIT_BYTES;
      prefill_ff <= 4'(`PREFILL_UNITS << 1);
      swing_out_ff <= `RST_REDUCED_SWING;
      pair0_ff <= 1'b0;
      pair1_ff <= 1'b0;
      rate_ff <= 1'b0;
    end
    else
    begin
      depth_ff <= nxt_depth;
      prefill_ff <= nxt_prefill;
      swing_out_ff <= nxt_swing_out;
      pair0_ff <= nxt_pair0;
      pair1_ff <= nxt_pair1;
      rate_ff <= nxt_rate;
    end
  end

  assign FIFO_DEPTH_BYTES = depth_ff;
  assign FIFO_PREFILL_NIBBLES = prefill_ff;
  assign REDUCED_SWING_10M = swing_out_ff;
  assign TEST_PAIR0_EN = pair0_ff;
  assign TEST_PAIR1_EN = pair1_ff;
  assign TEST_RATE_10M = rate_ff;

endmodule

/* verilog/phy_misc_cfg.svh */
`ifndef PHY_MISC_CFG_SVH
`define PHY_MISC_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_TX_SOP_DELAY 16'h942a
`define OFS_FIFO_DEPTH_UNIT 16'h9602
`define OFS_WAKE_FAULT_COUNT 16'ha000
`define OFS_REDUCED_SWING 16'hb403
`define OFS_TEST_WAVE_10M 16'hb412

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DLY10_MSB 12
`define DLY10_LSB 8
`define DLY100_MSB 7
`define DLY100_LSB 4
`define UNIT_BIT 0
`define SWING_BIT 0
`define WAVE_MSB 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_DLY10 5'h00
`define RST_DLY100 4'h0
`define RST_UNIT_BYTES 1'b1
`define RST_REDUCED_SWING 1'b1
`define RST_WAVE_SEL 3'h0

// ----------------------------------------------------------------------------
// Test waveform codes
// ----------------------------------------------------------------------------
`define WAVE_OFF 3'h0
`define WAVE_10M_PAIR0 3'h1
`define WAVE_10M_PAIR1 3'h2
`define WAVE_5M_PAIR0 3'h3
`define WAVE_5M_PAIR1 3'h4

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define DELAY_UNIT_NS 8
`define CLK_PERIOD_NS 100
`define PREFILL_UNITS 4'h2

`endif

/* verilog/phy_misc_pkg.sv */
package phy_misc_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } mgmt_req_type;

  typedef struct packed {
    logic [15:0] rdata;
    logic rvalid;
  } mgmt_rsp_type;

  typedef enum logic [0:0] {
    DLY_IDLE = 1'b0,
    DLY_COUNT = 1'b1
  } delay_state_type;

endpackage

/* verilog/sop_tx_delay.sv */
`timescale 1ns/10ps
`include "phy_misc_cfg.svh"

module sop_tx_delay
  import phy_misc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] delay_ns,
  output logic pulse
);

  delay_state_type state_ff, nxt_state;
  logic [7:0] rem_ff, nxt_rem;
  logic pulse_ff, nxt_pulse;
  localparam logic [7:0] PERIOD = 8'(`CLK_PERIOD_NS);

  // --------------------------------------------------------------------------
  // The remaining delay is kept in ns and drained one clock period per cycle.
  // --------------------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_rem = rem_ff;
    nxt_pulse = 1'b0;
    unique case (state_ff)
      DLY_IDLE:
      begin
        if (start)
        begin
          if (delay_ns == 8'h00)
            nxt_pulse = 1'b1;
          else
          begin
            nxt_rem = delay_ns;
            nxt_state = DLY_COUNT;
          end
        end
      end
      DLY_COUNT:
      begin
        if (rem_ff <= PERIOD)
        begin
          nxt_pulse = 1'b1;
          nxt_state = DLY_IDLE;
        end
        else
          nxt_rem = rem_ff - PERIOD;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= DLY_IDLE;
      rem_ff <= 8'h00;
      pulse_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      rem_ff <= nxt_rem;
      pulse_ff <= nxt_pulse;
    end
  end

  assign pulse = pulse_ff;

endmodule

/* verilog/wake_fault_counter.sv */
`timescale 1ns/10ps

module wake_fault_counter
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fault,
  input wire logic clear,
  output logic [15:0] count
);

  logic [15:0] count_ff, nxt_count;

  // A fault in the clearing cycle is kept as the first count after the clear.
  always_comb
  begin
    if (clear)
      nxt_count = {15'h0000, fault};
    else if (fault && (count_ff != 16'hffff))
      nxt_count = count_ff + 16'h0001;
    else
      nxt_count = count_ff;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count_ff <= 16'h0000;
    else
      count_ff <= nxt_count;
  end

  assign count = count_ff;

endmodule

/* tb/phy_misc_monitor.sv */
`timescale 1ns/10ps
`include "phy_misc_cfg.svh"
module phy_misc_monitor
  import phy_misc_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire mgmt_req_type MGMT_REQ,
  input wire mgmt_rsp_type MGMT_RSP,
  input wire logic TX_DETECT_EN,
  input wire logic TX_START_IND,
  input wire logic FIFO_DEPTH_BYTES,
  input wire logic [3:0] FIFO_PREFILL_NIBBLES,
  input wire logic REDUCED_SWING_10M,
  input wire logic TEST_PAIR0_EN,
  input wire logic TEST_PAIR1_EN,
  input wire logic TEST_RATE_10M
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence wr_at(logic [15:0] a);
    MGMT_REQ.wr && MGMT_REQ.addr == a;
  endsequence
  sequence quiet5;
    !TX_DETECT_EN [*5];
  endsequence
  a_read_answer: assert property (MGMT_RSP.rvalid == $past(MGMT_REQ.rd))
    else $error("read answer timing wrong");
  a_rdata_idle: assert property (!MGMT_RSP.rvalid |-> MGMT_RSP.rdata == 16'h0000)
    else $error("read data not zero when idle");
  a_prefill_unit: assert property (FIFO_PREFILL_NIBBLES == (FIFO_DEPTH_BYTES ? 4'h4 : 4'h2))
    else $error("prefill does not follow depth unit");
  a_ind_needs_en: assert property (quiet5 |-> !TX_START_IND)
    else $error("start indication while detection disabled");
  a_swing_write: assert property (wr_at(`OFS_REDUCED_SWING) |-> ##2 REDUCED_SWING_10M == $past(MGMT_REQ.wdata[0], 2))
    else $error("reduced swing output wrong after write");
  a_unit_write: assert property (wr_at(`OFS_FIFO_DEPTH_UNIT) |-> ##2 FIFO_DEPTH_BYTES == $past(MGMT_REQ.wdata[0], 2))
    else $error("depth unit output wrong after write");
  a_pair0_code: assert property (wr_at(`OFS_TEST_WAVE_10M) |->
    ##2 TEST_PAIR0_EN == ($past(MGMT_REQ.wdata[2:0], 2) inside {3'h1, 3'h3}))
    else $error("pair 0 enable wrong after write");
  a_pair1_code: assert property (wr_at(`OFS_TEST_WAVE_10M) |->
    ##2 TEST_PAIR1_EN == ($past(MGMT_REQ.wdata[2:0], 2) inside {3'h2, 3'h4}))
    else $error("pair 1 enable wrong after write");
  a_rate_code: assert property (wr_at(`OFS_TEST_WAVE_10M) ##0 (MGMT_REQ.wdata[2:0] inside {[3'h1:3'h4]}) |->
    ##2 TEST_RATE_10M == ($past(MGMT_REQ.wdata[2:0], 2) < 3'h3))
    else $error("test rate wrong after write");
endmodule

bind phy_misc_extended_regs phy_misc_monitor mon_u (.CLK_SYS(CLK_SYS), .RST(RST), .MGMT_REQ(MGMT_REQ),
  .MGMT_RSP(MGMT_RSP), .TX_DETECT_EN(TX_DETECT_EN), .TX_START_IND(TX_START_IND),
  .FIFO_DEPTH_BYTES(FIFO_DEPTH_BYTES), .FIFO_PREFILL_NIBBLES(FIFO_PREFILL_NIBBLES),
  .REDUCED_SWING_10M(REDUCED_SWING_10M), .TEST_PAIR0_EN(TEST_PAIR0_EN), .TEST_PAIR1_EN(TEST_PAIR1_EN),
  .TEST_RATE_10M(TEST_RATE_10M));

/* tb/mgmt_host_model.sv */
`timescale 1ns/10ps
module mgmt_host_model
  import phy_misc_pkg::*;
(
  input wire logic clk,
  input wire mgmt_rsp_type rsp,
  output mgmt_req_type req
);
  initial req = '0;
  task automatic put(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    req = '0;
  endtask
  // A read whose answer is missing returns unknown so that it never matches.
  task automatic get(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk);
    req = '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    // The answer stands for the one cycle after the request edge, so it is taken here.
    req = '0;
    d = (rsp.rvalid === 1'b1) ? rsp.rdata : 16'hxxxx;
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/10ps
`include "phy_misc_cfg.svh"
module tb_top
  import phy_misc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic spd = 1'b0, det = 1'b1, fuse = 1'b0, fst = 1'b0, mst = 1'b0, wk = 1'b0;
  logic ind, dbytes, swing, p0, p1, r10;
  logic [3:0] pre;
  mgmt_req_type req;
  mgmt_rsp_type rsp;
  int failures = 0, n_tests = 0, cyc = 0;
  initial forever #50 clk_sys = ~clk_sys;
  phy_misc_extended_regs dut_u (.CLK_SYS(clk_sys), .RST(rst), .MGMT_REQ(req), .MGMT_RSP(rsp),
    .LINK_SPEED_100(spd), .TX_DETECT_EN(det), .TX_FIFO_IN_USE(fuse), .TX_FIFO_FRAME_START(fst),
    .TX_MII_FRAME_START(mst), .WAKE_FAULT(wk), .TX_START_IND(ind), .FIFO_DEPTH_BYTES(dbytes),
    .FIFO_PREFILL_NIBBLES(pre), .REDUCED_SWING_10M(swing), .TEST_PAIR0_EN(p0), .TEST_PAIR1_EN(p1),
    .TEST_RATE_10M(r10));
  mgmt_host_model host_u (.clk(clk_sys), .rsp(rsp), .req(req));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_reset();
    logic [15:0] v;
    logic [15:0] ofs [6] = '{`OFS_TX_SOP_DELAY, `OFS_FIFO_DEPTH_UNIT, `OFS_WAKE_FAULT_COUNT,
      `OFS_REDUCED_SWING, `OFS_TEST_WAVE_10M, 16'h1234};
    logic [15:0] rv [6] = '{16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
    host_u.put(16'h1234, 16'hffff);
    host_u.put(`OFS_WAKE_FAULT_COUNT, 16'h1234);
    foreach (ofs[i])
    begin
      host_u.get(ofs[i], v);
      chk(v, rv[i]);
    end
    chk(pre, 4'h4);
    chk(dbytes, 1'b1);
    chk(swing, 1'b1);
  endtask
  task automatic t_start();
    logic [15:0] v;
    int n, d;
    logic [15:0] w [4] = '{16'h1400, 16'h0000, 16'h00f0, 16'h1f00};
    logic s [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    host_u.put(`OFS_TX_SOP_DELAY, 16'hffff);
    host_u.get(`OFS_TX_SOP_DELAY, v);
    chk(v, 16'h1ff0);
    foreach (w[i])
    begin
      host_u.put(`OFS_TX_SOP_DELAY, w[i]);
      spd = s[i];
      fuse = w[i][7] | w[i][12];
      d = s[i] ? w[i][7:4] : w[i][12:8];
      @(negedge clk_sys);
      fst = fuse;
      mst = !fuse;
      n = 0;
      do
      begin
        @(negedge clk_sys);
        fst = 1'b0;
        mst = 1'b0;
        n++;
      end
      while (ind !== 1'b1 && n < 6);
      chk(n, 1 + (d * 8 + 99) / 100);
    end
    det = 1'b0;
    fst = 1'b1;
    mst = 1'b1;
    @(negedge clk_sys);
    fst = 1'b0;
    mst = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk(ind, 1'b0);
    det = 1'b1;
  endtask
  task automatic t_units();
    logic [15:0] v;
    host_u.put(`OFS_FIFO_DEPTH_UNIT, 16'hfffe);
    host_u.get(`OFS_FIFO_DEPTH_UNIT, v);
    chk(v, 16'h0000);
    chk(dbytes, 1'b0);
    chk(pre, 4'h2);
    host_u.put(`OFS_REDUCED_SWING, 16'h0000);
    host_u.get(`OFS_REDUCED_SWING, v);
    chk(v, 16'h0000);
    chk(swing, 1'b0);
  endtask
  task automatic t_wave();
    logic [15:0] v;
    for (int c = 1; c <= 5; c++)
    begin
      host_u.put(`OFS_TEST_WAVE_10M, 16'(c % 5));
      host_u.get(`OFS_TEST_WAVE_10M, v);
      chk(v, 16'(c % 5));
      chk(p0, c == 1 || c == 3);
      chk(p1, c == 2 || c == 4);
      if (c < 5)
        chk(r10, c < 3);
    end
  endtask
  task automatic t_wake();
    logic [15:0] v;
    wk = 1'b1;
    repeat (3) @(negedge clk_sys);
    wk = 1'b0;
    host_u.get(`OFS_WAKE_FAULT_COUNT, v);
    chk(v, 16'h0003);
    host_u.get(`OFS_WAKE_FAULT_COUNT, v);
    chk(v, 16'h0000);
    wk = 1'b1;
    repeat (65540) @(negedge clk_sys);
    wk = 1'b0;
    host_u.get(`OFS_WAKE_FAULT_COUNT, v);
    chk(v, 16'hffff);
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_start();
    t_units();
    t_wave();
    t_wake();
    tally_and_finish();
  end
endmodule
